// ==== src/ext_irq_pkg.sv ====
// constants and types shared by the external interrupt input block
package ext_irq_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] cfg_offset      = 8'hE4;
   localparam logic [7:0] timer_control_reg_offset     = 8'h88;
   localparam logic [7:0] irq_stat_offset = 8'hF0;
   localparam logic [7:0] irq_mask_offset = 8'hF1;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int cfg_sel0_lsb  = 0;
   localparam int cfg_pol0_bit  = 3;
   localparam int cfg_sel1_lsb  = 4;
   localparam int cfg_pol1_bit  = 7;
   localparam int timer_control_reg_it0_bit  = 0;
   localparam int timer_control_reg_ie0_bit  = 1;
   localparam int timer_control_reg_it1_bit  = 2;
   localparam int timer_control_reg_ie1_bit  = 3;
   localparam int sel_width     = 3;

   // ----------------------------------------
   // reset values and encodings
   // ----------------------------------------
   localparam logic [7:0] cfg_reset     = 8'h00;
   localparam logic       trig_edge     = 1'h1;
   localparam logic       pol_high      = 1'h1;

endpackage

// ==== src/pin_sync.sv ====
// two-flop synchroniser for port pins
`timescale 1ns/1ns
module pin_sync #(
   parameter int width = 8
) (
   input  wire logic             clock,     // system clock
   input  wire logic             sys_rst,   // sync reset
   input  wire logic             clk_en,    // clock enable
   input  wire logic [width-1:0] async_in,  // raw pins
   output logic      [width-1:0] sync_out   // synchronised pins
);
   logic [width-1:0] meta_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // pin_sync

// ==== src/irq_channel.sv ====
// one external interrupt channel: pin select, polarity, edge/level flag
`timescale 1ns/1ns
module irq_channel (
   input  wire logic       clock,      // system clock
   input  wire logic       sys_rst,    // sync reset
   input  wire logic       clk_en,     // clock enable
   input  wire logic [7:0] pins,       // synchronised port-0 pins
   input  wire logic [2:0] pin_select, // pin choice
   input  wire logic       polarity,   // 1 active high
   input  wire logic       trig_type,  // 1 edge, 0 level
   input  wire logic       vector_ack, // cpu vectors to this isr
   input  wire logic       sw_set,     // software writes flag to 1
   input  wire logic       sw_clr,     // software writes flag to 0
   output logic            pending,    // pending flag
   output logic            active_edge // one-cycle edge event
);
   logic active;
   logic active_prev_reg;
   logic edge_flag_reg;

   // pin picked by select, observed only
   assign active = pins[pin_select] == ext_irq_pkg::pol_high ? polarity : ~polarity;

   assign active_edge = active & ~active_prev_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         // synced pins come out of reset low, so the default active-low input reads active
         // and would look like a fresh edge if the previous value started inactive
         active_prev_reg <= 1'h1;
      end else if (clk_en) begin
         active_prev_reg <= active;
      end
   end

   // set wins over clears
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         edge_flag_reg <= 1'h0;
      end else if (clk_en) begin
         if (active_edge || sw_set) begin
            edge_flag_reg <= 1'h1;
         end else if (vector_ack || sw_clr) begin
            edge_flag_reg <= 1'h0;
         end
      end
   end

   assign pending = (trig_type == ext_irq_pkg::trig_edge) ? edge_flag_reg : active;
endmodule // irq_channel

// ==== src/ext_irq_inputs.sv ====
// external interrupt inputs block with register port
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module ext_irq_inputs (
   input  wire logic       clock,        // 50 MHz system clock
   input  wire logic       sys_rst,      // sync reset, active high
   input  wire logic       clk_en,       // freezes state when low
   input  wire logic [7:0] port_zero,    // port-0 pins, asynchronous
   input  wire logic [7:0] reg_addr,     // register address
   input  wire logic [7:0] reg_wdata,    // write data
   input  wire logic       reg_wr,       // write strobe
   input  wire logic       reg_rd,       // read strobe
   input  wire logic       vector_zero,  // cpu vectors to input-zero isr
   input  wire logic       vector_one,   // cpu vectors to input-one isr
   output logic [7:0]      reg_rdata,    // read data, cycle after strobe
   output logic            irq_zero_pending, // flag to cpu
   output logic            irq_one_pending,  // flag to cpu
   output logic            irq_out       // masked status interrupt
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] external_irq_config_reg;
   logic [7:0] timer_control_reg_reg;       // trigger bits 0 and 2 only
   logic [1:0] stat_reg;
   logic [1:0] mask_reg;
   logic [7:0] pins_sync;
   logic       pend0;
   logic       pend1;
   logic       edge0;
   logic       edge1;
   logic       wr_cfg;
   logic       wr_timer_control_reg;
   logic [1:0] ev;

   assign wr_cfg  = reg_wr && reg_addr == ext_irq_pkg::cfg_offset;
   assign wr_timer_control_reg = reg_wr && reg_addr == ext_irq_pkg::timer_control_reg_offset;

   pin_sync #(.width(8)) u_sync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .async_in (port_zero),
      .sync_out (pins_sync)
   );

   // ----------------------------------------
   // channels
   // ----------------------------------------
   irq_channel u_ch0 (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .clk_en      (clk_en),
      .pins        (pins_sync),
      .pin_select  (external_irq_config_reg[ext_irq_pkg::cfg_sel0_lsb +: ext_irq_pkg::sel_width]),
      .polarity    (external_irq_config_reg[ext_irq_pkg::cfg_pol0_bit]),
      .trig_type   (timer_control_reg_reg[ext_irq_pkg::timer_control_reg_it0_bit]),
      .vector_ack  (vector_zero),
      .sw_set      (wr_timer_control_reg && reg_wdata[ext_irq_pkg::timer_control_reg_ie0_bit]),
      .sw_clr      (wr_timer_control_reg && !reg_wdata[ext_irq_pkg::timer_control_reg_ie0_bit]),
      .pending     (pend0),
      .active_edge (edge0)
   );

   irq_channel u_ch1 (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .clk_en      (clk_en),
      .pins        (pins_sync),
      .pin_select  (external_irq_config_reg[ext_irq_pkg::cfg_sel1_lsb +: ext_irq_pkg::sel_width]),
      .polarity    (external_irq_config_reg[ext_irq_pkg::cfg_pol1_bit]),
      .trig_type   (timer_control_reg_reg[ext_irq_pkg::timer_control_reg_it1_bit]),
      .vector_ack  (vector_one),
      .sw_set      (wr_timer_control_reg && reg_wdata[ext_irq_pkg::timer_control_reg_ie1_bit]),
      .sw_clr      (wr_timer_control_reg && !reg_wdata[ext_irq_pkg::timer_control_reg_ie1_bit]),
      .pending     (pend1),
      .active_edge (edge1)
   );

   // ----------------------------------------
   // configuration writes
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         external_irq_config_reg <= ext_irq_pkg::cfg_reset;
      end else if (clk_en && wr_cfg) begin
         external_irq_config_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         timer_control_reg_reg <= 8'h00;
      end else if (clk_en && wr_timer_control_reg) begin
         timer_control_reg_reg[ext_irq_pkg::timer_control_reg_it0_bit] <= reg_wdata[ext_irq_pkg::timer_control_reg_it0_bit];
         timer_control_reg_reg[ext_irq_pkg::timer_control_reg_it1_bit] <= reg_wdata[ext_irq_pkg::timer_control_reg_it1_bit];
      end
   end

   // ----------------------------------------
   // sticky status, mask, interrupt
   // ----------------------------------------
   assign ev = {edge1, edge0};

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat_reg <= 2'h0;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == ext_irq_pkg::irq_stat_offset) begin
            stat_reg <= (stat_reg & ~reg_wdata[1:0]) | ev;
         end else begin
            stat_reg <= stat_reg | ev;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mask_reg <= 2'h0;
      end else if (clk_en && reg_wr && reg_addr == ext_irq_pkg::irq_mask_offset) begin
         mask_reg <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_out          <= 1'h0;
         irq_zero_pending <= 1'h0;
         irq_one_pending  <= 1'h0;
      end else if (clk_en) begin
         irq_out          <= |(stat_reg & mask_reg);
         irq_zero_pending <= pend0;
         irq_one_pending  <= pend1;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            unique case (reg_addr)
               ext_irq_pkg::cfg_offset:      reg_rdata <= external_irq_config_reg;
               ext_irq_pkg::timer_control_reg_offset:     reg_rdata <= {4'h0, pend1, timer_control_reg_reg[2], pend0,
                                                           timer_control_reg_reg[0]};
               ext_irq_pkg::irq_stat_offset: reg_rdata <= {6'h00, stat_reg};
               ext_irq_pkg::irq_mask_offset: reg_rdata <= {6'h00, mask_reg};
               default:                      reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // ext_irq_inputs

// ==== dv/ext_irq_src.sv ====
// external interrupt source model driving the port-0 pins
`timescale 1ns/1ns
module ext_irq_src (
   input  wire logic       clock, // system clock
   input  wire logic [7:0] want,  // requested pin levels
   output logic      [7:0] pins   // port-0 pins
);
   initial pins = 8'hFF;
   // a level stands until the bench withdraws it after recognition
   // pins used only for interrupts are taken as skipped by the crossbar
   always @(posedge clock) pins <= want;
endmodule // ext_irq_src

// ==== dv/ext_irq_inputs_sva.sv ====
// assertion checker bound to the external interrupt inputs block
`timescale 1ns/1ns
module ext_irq_chk (
   input wire logic       clock,            // clock
   input wire logic       sys_rst,          // reset
   input wire logic       clk_en,           // enable
   input wire logic [7:0] port_zero,        // pins
   input wire logic [7:0] reg_addr,         // address
   input wire logic [7:0] reg_wdata,        // write data
   input wire logic       reg_wr,           // write
   input wire logic       reg_rd,           // read
   input wire logic       vector_zero,      // vector 0
   input wire logic       vector_one,       // vector 1
   input wire logic [7:0] reg_rdata,        // read data
   input wire logic       irq_zero_pending, // flag 0
   input wire logic       irq_one_pending,  // flag 1
   input wire logic       irq_out           // interrupt
);
   logic [7:0] cfg_reg;
   logic [1:0] trg_reg;
   logic       act0;
   logic       act1;
   assign act0 = port_zero[cfg_reg[2:0]] == cfg_reg[3];
   assign act1 = port_zero[cfg_reg[6:4]] == cfg_reg[7];
   // shadow of what software configured
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cfg_reg <= 8'h00;
         trg_reg <= 2'h0;
      end else if (clk_en && reg_wr && reg_addr == ext_irq_pkg::cfg_offset) begin
         cfg_reg <= reg_wdata;
      end else if (clk_en && reg_wr && reg_addr == ext_irq_pkg::timer_control_reg_offset) begin
         trg_reg <= {reg_wdata[2], reg_wdata[0]};
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_cfg_read_back:
      assert property (clk_en && reg_wr && reg_addr == ext_irq_pkg::cfg_offset ##1 clk_en
         && reg_rd && reg_addr == ext_irq_pkg::cfg_offset |=> reg_rdata == $past(reg_wdata, 2))
      else $error("config read back differs");
   chk_rd_idle_zero:
      assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data without read");
   chk_lvl_zero_follow:
      assert property ((!trg_reg[0] && $stable(act0) && $stable(cfg_reg))[*6]
         |-> irq_zero_pending == act0)
      else $error("level flag zero wrong");
   chk_lvl_one_follow:
      assert property ((!trg_reg[1] && $stable(act1) && $stable(cfg_reg))[*6]
         |-> irq_one_pending == act1)
      else $error("level flag one wrong");
   chk_edge_zero_set:
      assert property ((trg_reg[0] && !act0 && $stable(cfg_reg))[*3] ##1 (trg_reg[0] && act0
         && !vector_zero && !reg_wr && $stable(cfg_reg))[*5] |-> irq_zero_pending)
      else $error("edge flag zero not set");
   chk_edge_one_set:
      assert property ((trg_reg[1] && !act1 && $stable(cfg_reg))[*3] ##1 (trg_reg[1] && act1
         && !vector_one && !reg_wr && $stable(cfg_reg))[*5] |-> irq_one_pending)
      else $error("edge flag one not set");
   chk_vec_zero_clr:
      assert property ((trg_reg[0] && $stable(port_zero) && $stable(cfg_reg) && !reg_wr)[*6]
         ##0 vector_zero |-> ##[1:2] !irq_zero_pending)
      else $error("vector left flag zero");
   chk_vec_one_clr:
      assert property ((trg_reg[1] && $stable(port_zero) && $stable(cfg_reg) && !reg_wr)[*6]
         ##0 vector_one |-> ##[1:2] !irq_one_pending)
      else $error("vector left flag one");
   cover property (vector_zero && irq_zero_pending);
   cover property (trg_reg == 2'h0 && irq_one_pending);
   cover property (irq_out);
endmodule // ext_irq_chk
bind ext_irq_inputs ext_irq_chk ext_irq_chk_i (.*);

// ==== dv/tb_ext_irq_inputs.sv ====
// self-checking bench for the external interrupt inputs block
`timescale 1ns/1ns
module tb_ext_irq_inputs;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] want = 8'hFF;
   logic [7:0] pins;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       vec = 1'b0;
   logic [7:0] rdata;
   logic       pend0;
   logic       pend1;
   logic       irq;
   int         n_fail = 0;
   int         num_checks = 0;
   int         cyc = 0;
   int         seed = 20240;
   int         t, p, lat, e;
   always #10 clock = ~clock;
   ext_irq_src ext_irq_src_i (.clock(clock), .want(want), .pins(pins));
   ext_irq_inputs ext_irq_inputs_i (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
      .port_zero(pins), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .vector_zero(vec), .vector_one(vec), .reg_rdata(rdata), .irq_zero_pending(pend0),
      .irq_one_pending(pend1), .irq_out(irq));
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, 1'b1, a, 8'h00);
      idle(1);
      #1 chk(rdata, exp);
   endtask
   // input one uses the opposite polarity and the mirrored pin
   task automatic drive_pins(input int a, input int s);
      logic [7:0] r;
      r = 8'($random(seed));
      r[s] = a[0] ~^ p[0];
      r[7 - s] = a[0] ^ p[0];
      want <= r;
   endtask
   task automatic cmp_flags(input int a);
      e = t ? lat : a;
      #1;
      chk({7'h00, pend0}, e[7:0]);
      chk({7'h00, pend1}, e[7:0]);
      rdc(ext_irq_pkg::timer_control_reg_offset, {4'h0, e[0], t[0], e[0], t[0]});
   endtask
   task automatic irq_is(input logic x);
      idle(3);
      #1 chk({7'h00, irq}, {7'h00, x});
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      idle(4);
      sys_rst <= 1'b0;
      rdc(ext_irq_pkg::cfg_offset, 8'h00);
      rdc(8'h00, 8'h00);
      for (int i = 0; i < 8; i++) begin
         t = i % 2;
         p = (i / 2) % 2;
         idle(1);
         drive_pins(0, i);
         bus(1'b1, 1'b0, ext_irq_pkg::cfg_offset, {~p[0], 3'(7 - i), p[0], 3'(i)});
         rdc(ext_irq_pkg::cfg_offset, {~p[0], 3'(7 - i), p[0], 3'(i)});
         idle(4);
         bus(1'b1, 1'b0, ext_irq_pkg::timer_control_reg_offset, {5'h00, t[0], 1'b0, t[0]});
         idle(8);
         lat = 0;
         cmp_flags(0);
         idle(1);
         drive_pins(1, i);
         idle(8);
         lat = t;
         cmp_flags(1);
         idle(1);
         drive_pins(0, i);
         idle(8);
         cmp_flags(0);
         idle(1);
         vec <= 1'b1;
         idle(1);
         vec <= 1'b0;
         idle(4);
         lat = 0;
         cmp_flags(0);
      end
      bus(1'b1, 1'b0, ext_irq_pkg::irq_mask_offset, 8'h01);
      bus(1'b1, 1'b0, ext_irq_pkg::irq_stat_offset, 8'h03);
      irq_is(1'b0);
      idle(1);
      drive_pins(1, 7);
      idle(5);
      irq_is(1'b1);
      rdc(ext_irq_pkg::irq_stat_offset, 8'h03);
      bus(1'b1, 1'b0, ext_irq_pkg::irq_mask_offset, 8'h00);
      irq_is(1'b0);
      bus(1'b1, 1'b0, ext_irq_pkg::irq_mask_offset, 8'h02);
      irq_is(1'b1);
      bus(1'b1, 1'b0, ext_irq_pkg::irq_stat_offset, 8'h02);
      irq_is(1'b0);
      rdc(ext_irq_pkg::irq_stat_offset, 8'h01);
      print_verdict();
   end
endmodule // tb_ext_irq_inputs
